// >>> src/power_management_clock_control.sv
// Clock divider, switchback and crystal/ring control with its status registers
`timescale 1ns/1ps
module power_management_clock_control
    import pmm_clock_pkg::*;
#(
    parameter int NUM_EXT_IRQ   = 6,
    parameter int WARMUP        = WARMUP_CLOCKS
)(
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_b_i,
    input  wire logic [7:0]             sfr_addr_i,
    input  wire logic                   sfr_wr_i,
    input  wire logic [7:0]             sfr_wdata_i,
    output logic      [7:0]             sfr_rdata_o,
    input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_req_i,
    input  wire logic [NUM_EXT_IRQ-1:0] ext_irq_high_i,
    input  wire logic                   powerfail_level_active_i,
    input  wire logic                   high_level_active_i,
    input  wire logic                   low_level_active_i,
    input  wire logic [1:0]             rx_enable_i,
    input  wire logic [1:0]             rx_start_i,
    input  wire logic [1:0]             rx_busy_i,
    input  wire logic [1:0]             tx_busy_i,
    input  wire logic                   xtal_osc_stable_i,
    output logic                        cycle_en_o,
    output div_code_t                   div_active_o,
    output logic                        ring_active_flag_o,
    output logic                        crystal_amp_off_o,
    output logic                        switchback_o
);

    // ***********************************
    // Declarations
    // ***********************************
    div_code_t  divider_sel_ff;
    logic       auto_return_enable_ff;
    logic       crystal_amp_off_ff;
    logic       clock_source_select_ff;
    logic [1:0] settle_ff;
    logic       osc_meta_ff;
    logic       osc_sync_ff;
    logic       crystal_ready;
    logic       cycle_tick;
    logic       wr_power;
    logic       wr_ext_flag;
    logic       wr_tx_buffer;
    logic       ext_takeable;
    logic       rx_start_seen;
    logic       switchback_event;
    logic       settle_done;
    logic       div_write_ok;
    div_code_t  div_wr_code;
    logic [7:0] status_value;

    // ***********************************
    // Helpers
    // ***********************************
    cycle_divider u_cycle_divider (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .div_sel_i (div_active_o),
        .tick_o    (cycle_tick)
    );

    crystal_warmup #(
        .WARMUP (WARMUP)
    ) u_crystal_warmup (
        .clk_sys_i    (clk_sys_i),
        .rst_b_i      (rst_b_i),
        .amp_off_i    (crystal_amp_off_ff),
        .osc_stable_i (osc_sync_ff),
        .ready_o      (crystal_ready)
    );

    // Analog stable indication arrives asynchronously
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_meta_ff <= 1'b0;
            osc_sync_ff <= 1'b0;
        end else begin
            osc_meta_ff <= xtal_osc_stable_i;
            osc_sync_ff <= osc_meta_ff;
        end
    end

    // ***********************************
    // Decode and switchback sources
    // ***********************************
    assign wr_power     = sfr_wr_i && (sfr_addr_i == ADDR_POWER_MGMT);
    assign wr_ext_flag  = sfr_wr_i && (sfr_addr_i == ADDR_EXT_FLAG);
    assign wr_tx_buffer = sfr_wr_i && ((sfr_addr_i == ADDR_SERIAL0_BUF) ||
                                       (sfr_addr_i == ADDR_SERIAL1_BUF));
    assign div_wr_code  = div_code_t'(sfr_wdata_i[DIV_HI_BIT:DIV_LO_BIT]);

    // A low source is blocked by any low, high or power-fail service, a high one
    // only by high or power-fail service
    always_comb begin
        ext_takeable = 1'b0;
        for (int i = 0; i < NUM_EXT_IRQ; i++) begin
            if (ext_irq_req_i[i] && !powerfail_level_active_i &&
                (ext_irq_high_i[i] ? !high_level_active_i :
                 !(high_level_active_i || low_level_active_i))) begin
                ext_takeable = 1'b1;
            end
        end
    end

    assign rx_start_seen    = |(rx_start_i & rx_enable_i);
    assign switchback_event = auto_return_enable_ff &&
                              (ext_takeable || rx_start_seen || wr_tx_buffer);

    // Reduced codes only while the 4-clock rate is both set and running
    assign div_write_ok = (div_wr_code == DIV_4) ||
                          ((div_wr_code != DIV_RSVD) && (divider_sel_ff == DIV_4) &&
                           (div_active_o == DIV_4));

    // ***********************************
    // Apply delay
    // ***********************************
    // Divider and clock-source settings written now take effect at the end of the following full cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            settle_ff <= SETTLE_IDLE;
        end else if (wr_power || wr_ext_flag) begin
            settle_ff <= SETTLE_LOAD;
        end else if (cycle_tick && (settle_ff != SETTLE_IDLE)) begin
            settle_ff <= settle_ff - 1'b1;
        end
    end

    assign settle_done = cycle_tick && (settle_ff == SETTLE_LAST);

    // ***********************************
    // Divider control
    // ***********************************
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            divider_sel_ff <= DIV_4;
        end else if (switchback_event) begin
            divider_sel_ff <= DIV_4;
        end else if (wr_power && div_write_ok) begin
            divider_sel_ff <= div_wr_code;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_active_o <= DIV_4;
        end else if (switchback_event) begin
            div_active_o <= DIV_4;
        end else if (settle_done) begin
            div_active_o <= divider_sel_ff;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            auto_return_enable_ff <= 1'b0;
        end else if (wr_power) begin
            auto_return_enable_ff <= sfr_wdata_i[AUTO_RETURN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            switchback_o <= 1'b0;
            cycle_en_o   <= 1'b0;
        end else begin
            switchback_o <= switchback_event;
            cycle_en_o   <= cycle_tick;
        end
    end

    // ***********************************
    // Clock source control
    // ***********************************
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crystal_amp_off_ff <= 1'b0;
        end else if (wr_power) begin
            if (!sfr_wdata_i[XTAL_OFF_BIT]) begin
                crystal_amp_off_ff <= 1'b0;
            end else if (!clock_source_select_ff && ring_active_flag_o) begin
                crystal_amp_off_ff <= 1'b1;
            end
        end
    end

    // Switchback never touches the source select
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clock_source_select_ff <= RST_SRC_SEL;
        end else if (wr_ext_flag) begin
            if (!sfr_wdata_i[SRC_SEL_BIT]) begin
                clock_source_select_ff <= 1'b0;
            end else if (crystal_ready && !crystal_amp_off_ff) begin
                clock_source_select_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ring_active_flag_o <= 1'b0;
        end else if (settle_done) begin
            ring_active_flag_o <= !clock_source_select_ff;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crystal_amp_off_o <= 1'b0;
        end else begin
            crystal_amp_off_o <= crystal_amp_off_ff;
        end
    end

    // ***********************************
    // Read path
    // ***********************************
    // Status is pure reflection, so writes there have nothing to store
    assign status_value = {powerfail_level_active_i, high_level_active_i,
                           low_level_active_i, crystal_ready,
                           tx_busy_i[1], rx_busy_i[1], tx_busy_i[0], rx_busy_i[0]};

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= READ_ZERO;
        end else begin
            sfr_rdata_o <= READ_ZERO;
            unique case (sfr_addr_i)
                ADDR_POWER_MGMT: begin
                    sfr_rdata_o[DIV_HI_BIT:DIV_LO_BIT] <= divider_sel_ff;
                    sfr_rdata_o[AUTO_RETURN_BIT]      <= auto_return_enable_ff;
                    sfr_rdata_o[XTAL_OFF_BIT]         <= crystal_amp_off_ff;
                end
                ADDR_STATUS: begin
                    sfr_rdata_o <= status_value;
                end
                ADDR_EXT_FLAG: begin
                    sfr_rdata_o[SRC_SEL_BIT]   <= clock_source_select_ff;
                    sfr_rdata_o[RING_FLAG_BIT] <= ring_active_flag_o;
                end
                default: begin
                    sfr_rdata_o <= READ_ZERO;
                end
            endcase
        end
    end

    // ***********************************
    // Assertions
    // ***********************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    rsvd_code_ignored_a: assert property (
        wr_power && (div_wr_code == DIV_RSVD) && !switchback_event
        |=> divider_sel_ff == $past(divider_sel_ff))
        else $error("reserved divider code changed the setting");

    reduced_hop_blocked_a: assert property (
        wr_power && (div_wr_code == DIV_64) && (divider_sel_ff == DIV_1024)
        && !switchback_event |=> divider_sel_ff == DIV_1024)
        else $error("direct move between reduced rates accepted");

    switchback_restore_a: assert property (
        switchback_event |=> (divider_sel_ff == DIV_4) && (div_active_o == DIV_4)
        && switchback_o)
        else $error("switchback did not restore the 4-clock rate");

    blocked_level_a: assert property (
        auto_return_enable_ff && high_level_active_i && !(|(ext_irq_req_i & ext_irq_high_i))
        && !rx_start_seen && !wr_tx_buffer |-> !switchback_event)
        else $error("blocked interrupt caused switchback");

    apply_on_cycle_a: assert property (
        (div_active_o != $past(div_active_o)) |-> $past(cycle_tick || switchback_event))
        else $error("divider applied outside a cycle boundary");

    no_early_apply_a: assert property (
        wr_power && div_write_ok && (div_wr_code != div_active_o) && !switchback_event
        ##1 !cycle_tick |=> div_active_o == $past(div_active_o, 2))
        else $error("divider applied before a full cycle");

    amp_off_guard_a: assert property (
        wr_power && sfr_wdata_i[XTAL_OFF_BIT] && clock_source_select_ff
        && !crystal_amp_off_ff |=> !crystal_amp_off_ff)
        else $error("crystal stopped while crystal selected");

    xtal_select_block_a: assert property (
        wr_ext_flag && sfr_wdata_i[SRC_SEL_BIT] && !clock_source_select_ff
        && (!crystal_ready || crystal_amp_off_ff) |=> !clock_source_select_ff)
        else $error("crystal selected before ready");

    ready_drop_a: assert property (
        crystal_amp_off_ff |=> !crystal_ready)
        else $error("crystal ready while amplifier off");

    source_kept_a: assert property (
        switchback_event && !wr_ext_flag |=> $stable(clock_source_select_ff))
        else $error("switchback changed clock source");

    ring_flag_cause_a: assert property (
        $rose(ring_active_flag_o) |-> $past(!clock_source_select_ff && cycle_tick))
        else $error("ring flag rose without ring selected");

    sb_seen_c: cover property (switchback_event && (div_active_o == DIV_1024));
    ready_rose_c: cover property ($rose(crystal_ready));
    ring_entered_c: cover property ($rose(ring_active_flag_o) ##[1:20] crystal_amp_off_ff);

endmodule : power_management_clock_control

// >>> include/pmm_clock_pkg.sv
// Constants shared by the clock control block and its helpers
package pmm_clock_pkg;

    // ***********************************
    // Special-function register addresses
    // ***********************************
    localparam logic [7:0] ADDR_POWER_MGMT   = 8'hC4;
    localparam logic [7:0] ADDR_STATUS       = 8'hC5;
    localparam logic [7:0] ADDR_EXT_FLAG     = 8'h91;
    localparam logic [7:0] ADDR_SERIAL1_BUF  = 8'hC1;
    // Port 0 buffer address; held as a constant so it can be retargeted
    localparam logic [7:0] ADDR_SERIAL0_BUF  = 8'h99;

    // ***********************************
    // Field positions
    // ***********************************
    localparam int DIV_HI_BIT       = 7;
    localparam int DIV_LO_BIT       = 6;
    localparam int AUTO_RETURN_BIT  = 5;
    localparam int XTAL_OFF_BIT     = 3;
    localparam int SRC_SEL_BIT      = 3;
    localparam int RING_FLAG_BIT    = 2;

    // ***********************************
    // Divider codes and counts
    // ***********************************
    typedef enum logic [1:0] {
        DIV_RSVD = 2'b00,
        DIV_4    = 2'b01,
        DIV_64   = 2'b10,
        DIV_1024 = 2'b11
    } div_code_t;

    localparam int          DIV_CNT_W     = 10;
    localparam logic [9:0]  DIV4_LAST     = 10'h003;
    localparam logic [9:0]  DIV64_LAST    = 10'h03F;
    localparam logic [9:0]  DIV1024_LAST  = 10'h3FF;

    // ***********************************
    // Crystal warm-up and apply delay
    // ***********************************
    localparam int          WARMUP_CLOCKS = 65536;
    localparam int          WARMUP_CNT_W  = 17;
    localparam logic [1:0]  SETTLE_LOAD   = 2'h2;
    localparam logic [1:0]  SETTLE_LAST   = 2'h1;
    localparam logic [1:0]  SETTLE_IDLE   = 2'h0;

    // ***********************************
    // Reset values
    // ***********************************
    localparam logic        RST_SRC_SEL   = 1'b1;
    localparam logic        RST_READY     = 1'b1;
    localparam logic [7:0]  READ_ZERO     = 8'h00;

endpackage : pmm_clock_pkg

// >>> src/cycle_divider.sv
// Instruction cycle enable generator: one pulse per 4, 64 or 1024 clocks
`timescale 1ns/1ps
module cycle_divider
    import pmm_clock_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire div_code_t  div_sel_i,
    output logic            tick_o
);

    logic [DIV_CNT_W-1:0] cnt_ff;
    logic [DIV_CNT_W-1:0] last_value;

    always_comb begin
        unique case (div_sel_i)
            DIV_64:   last_value = DIV64_LAST;
            DIV_1024: last_value = DIV1024_LAST;
            default:  last_value = DIV4_LAST;
        endcase
    end

    // Compare with >= so a shorter rate never waits for a counter wrap
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
            tick_o <= 1'b0;
        end else if (cnt_ff >= last_value) begin
            cnt_ff <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            tick_o <= 1'b0;
        end
    end

endmodule : cycle_divider

// >>> src/crystal_warmup.sv
// Crystal warm-up counter that raises the ready flag after the stable count
`timescale 1ns/1ps
module crystal_warmup
    import pmm_clock_pkg::*;
#(
    parameter int WARMUP = WARMUP_CLOCKS
)(
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    input  wire logic amp_off_i,
    input  wire logic osc_stable_i,
    output logic      ready_o
);

    logic [WARMUP_CNT_W-1:0] cnt_ff;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff  <= '0;
            ready_o <= RST_READY;
        end else if (amp_off_i) begin
            cnt_ff  <= '0;
            ready_o <= 1'b0;
        end else if (!ready_o && osc_stable_i) begin
            // Count only once the oscillator itself has started
            if (cnt_ff == WARMUP_CNT_W'(WARMUP - 1)) begin
                ready_o <= 1'b1;
            end
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

endmodule : crystal_warmup

// >>> verification/far_side_model.sv
// Model of the interrupt logic, serial ports and crystal oscillator
`timescale 1ns/1ps
module far_side_model
(
    input  wire logic       clk_sys_i,
    input  wire logic       amp_off_i,
    output logic [5:0]      ext_irq_req_o,
    output logic [5:0]      ext_irq_high_o,
    output logic [2:0]      level_o,
    output logic [1:0]      rx_enable_o,
    output logic [1:0]      rx_start_o,
    output logic [1:0]      rx_busy_o,
    output logic [1:0]      tx_busy_o,
    output logic            osc_stable_o
);
    int start_cnt = 5;
    initial begin
        {ext_irq_req_o, ext_irq_high_o, level_o, rx_start_o, rx_busy_o, tx_busy_o} = '0;
        rx_enable_o  = 2'h1;
        osc_stable_o = 1'b1;
    end
    // Amplifier needs a few clocks of start-up before the warm-up count may begin
    always @(negedge clk_sys_i) begin
        if (amp_off_i === 1'b1) begin
            start_cnt = 0;
            osc_stable_o <= 1'b0;
        end else if (start_cnt < 5) start_cnt++;
        else osc_stable_o <= 1'b1;
    end
    task automatic raise_irq(input logic hi);
        @(negedge clk_sys_i);
        ext_irq_high_o[0] = hi;
        ext_irq_req_o[0]  = 1'b1;
        @(negedge clk_sys_i);
        ext_irq_req_o[0]  = 1'b0;
    endtask : raise_irq
    // Wake-up character is a dummy; its content is never used
    task automatic rx_start_pulse();
        @(negedge clk_sys_i);
        rx_start_o[0] = 1'b1;
        @(negedge clk_sys_i);
        rx_start_o[0] = 1'b0;
    endtask : rx_start_pulse
    task automatic set_status(input logic [2:0] lv, input logic [1:0] rx, tx);
        @(negedge clk_sys_i);
        level_o   = lv;
        rx_busy_o = rx;
        tx_busy_o = tx;
    endtask : set_status
endmodule : far_side_model

// >>> verification/tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module tb;
    import pmm_clock_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    localparam row_t ROWS [7] = '{
        '{ADDR_POWER_MGMT, 8'h00, 8'h40}, '{ADDR_POWER_MGMT, 8'h20, 8'h60},
        '{ADDR_POWER_MGMT, 8'h28, 8'h60}, '{ADDR_POWER_MGMT, 8'h40, 8'h40},
        '{ADDR_STATUS, 8'hFF, 8'h10}, '{ADDR_EXT_FLAG, 8'h0C, 8'h08}, '{8'h80, 8'hFF, 8'h00}};
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
    logic wr = 1'b0, cycle_en, ring, amp_off, sb, osc;
    div_code_t div_active;
    logic [5:0] irq_req, irq_high;
    logic [2:0] lv;
    logic [1:0] rx_en, rx_st, rx_bz, tx_bz;
    int mismatches = 0, checks = 0, sb_cnt = 0, c0;
    always #20 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) if (sb === 1'b1) sb_cnt++;
    far_side_model fs (.clk_sys_i(clk_sys_i), .amp_off_i(amp_off), .ext_irq_req_o(irq_req),
        .ext_irq_high_o(irq_high), .level_o(lv), .rx_enable_o(rx_en), .rx_start_o(rx_st),
        .rx_busy_o(rx_bz), .tx_busy_o(tx_bz), .osc_stable_o(osc));
    power_management_clock_control #(.NUM_EXT_IRQ(6), .WARMUP(16)) DUT (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext_irq_req_i(irq_req),
        .ext_irq_high_i(irq_high), .powerfail_level_active_i(lv[2]),
        .high_level_active_i(lv[1]), .low_level_active_i(lv[0]), .rx_enable_i(rx_en),
        .rx_start_i(rx_st), .rx_busy_i(rx_bz), .tx_busy_i(tx_bz), .xtal_osc_stable_i(osc),
        .cycle_en_o(cycle_en), .div_active_o(div_active), .ring_active_flag_o(ring),
        .crystal_amp_off_o(amp_off), .switchback_o(sb));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk_sys_i);
        wr = 1'b0;
    endtask : wr_reg
    // Read data is registered, so it is sampled one full cycle after the address
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        addr = a;
        @(negedge clk_sys_i);
        d = rdata;
    endtask : rd_reg
    task automatic wait_div(input div_code_t e);
        int n;
        n = 0;
        while (div_active !== e && n < 3000) begin
            @(negedge clk_sys_i);
            n++;
        end
        check({14'h0, div_active}, {14'h0, e});
    endtask : wait_div
    task automatic period(input int e);
        int n;
        n = 0;
        while (cycle_en !== 1'b1 && n < 2100) begin
            @(negedge clk_sys_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (cycle_en !== 1'b1 && n < 2100);
        check(n[15:0], e[15:0]);
    endtask : period
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        #(40 * 40000);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        rd_reg(ADDR_POWER_MGMT, r); check(r, 8'h40);
        rd_reg(ADDR_STATUS, r); check(r, 8'h10);
        rd_reg(ADDR_EXT_FLAG, r); check(r, 8'h08);
        for (int i = 0; i < 7; i++) begin
            wr_reg(ROWS[i].a, ROWS[i].d);
            rd_reg(ROWS[i].a, r); check(r, ROWS[i].e);
        end
        // ***********************************
        // Divider rates and apply delay
        // ***********************************
        period(4);
        fs.set_status(3'h5, 2'h1, 2'h2);
        rd_reg(ADDR_STATUS, r); check(r, 8'hB9);
        fs.set_status(3'h0, 2'h0, 2'h0);
        wr_reg(ADDR_POWER_MGMT, 8'h80); check({14'h0, div_active}, 16'h0001);
        wait_div(DIV_64); period(64);
        wr_reg(ADDR_POWER_MGMT, 8'hC0); rd_reg(ADDR_POWER_MGMT, r); check(r, 8'h80);
        wr_reg(ADDR_POWER_MGMT, 8'h40); wait_div(DIV_4);
        wr_reg(ADDR_POWER_MGMT, 8'hC0); wait_div(DIV_1024); period(1024);
        wr_reg(ADDR_POWER_MGMT, 8'h40); wait_div(DIV_4);
        // ***********************************
        // Ring source and crystal gating
        // ***********************************
        wr_reg(ADDR_EXT_FLAG, 8'h00); check({15'h0, ring}, 16'h0000);
        repeat (12) @(negedge clk_sys_i);
        rd_reg(ADDR_EXT_FLAG, r); check(r, 8'h04);
        wr_reg(ADDR_POWER_MGMT, 8'h48); @(negedge clk_sys_i); check({15'h0, amp_off}, 16'h1);
        rd_reg(ADDR_STATUS, r); check(r, 8'h00);
        wr_reg(ADDR_EXT_FLAG, 8'h08); repeat (12) @(negedge clk_sys_i);
        rd_reg(ADDR_EXT_FLAG, r); check(r, 8'h04);
        // ***********************************
        // Switchback sources and blocking
        // ***********************************
        fs.set_status(3'h2, 2'h0, 2'h0);
        wr_reg(ADDR_POWER_MGMT, 8'hA8); wait_div(DIV_64);
        c0 = sb_cnt; fs.raise_irq(1'b0); repeat (3) @(negedge clk_sys_i);
        check(sb_cnt - c0, 16'h0); check({14'h0, div_active}, 16'h0002);
        fs.set_status(3'h0, 2'h0, 2'h0);
        for (int k = 0; k < 4; k++) begin
            wr_reg(ADDR_POWER_MGMT, 8'hA8); wait_div(DIV_64);
            c0 = sb_cnt;
            case (k)
                0: fs.raise_irq(1'b0);
                1: fs.rx_start_pulse();
                2: wr_reg(ADDR_SERIAL0_BUF, 8'h55);
                default: wr_reg(ADDR_SERIAL1_BUF, 8'hAA);
            endcase
            repeat (2) @(negedge clk_sys_i);
            check(sb_cnt - c0, 16'h1); check({14'h0, div_active}, 16'h0001);
            check({15'h0, ring}, 16'h0001);
        end
        wr_reg(ADDR_POWER_MGMT, 8'h88); wait_div(DIV_64);
        c0 = sb_cnt; fs.raise_irq(1'b1); repeat (3) @(negedge clk_sys_i);
        check(sb_cnt - c0, 16'h0); check({14'h0, div_active}, 16'h0002);
        // ***********************************
        // Crystal restart and return to crystal
        // ***********************************
        // Look before the slow-rate apply delay, which outlasts the short warm-up
        wr_reg(ADDR_POWER_MGMT, 8'h40); rd_reg(ADDR_STATUS, r); check(r, 8'h00);
        wait_div(DIV_4); repeat (40) @(negedge clk_sys_i);
        rd_reg(ADDR_STATUS, r); check(r, 8'h10);
        wr_reg(ADDR_EXT_FLAG, 8'h08); repeat (12) @(negedge clk_sys_i);
        rd_reg(ADDR_EXT_FLAG, r); check(r, 8'h08);
        give_verdict();
    end
endmodule : tb
